// ==== logic/scs_pkg.sv ====
`default_nettype none
package scs_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_MHZ = 100;
  localparam int unsigned SRST_WAIT_NS = 1000;
  // Least time, so round up
  localparam int unsigned SRST_WAIT_CYC = (SRST_WAIT_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned CAL_CYCLES_DEF = 1024;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LINK_CFG = 8'h04;
  localparam logic [7:0] OFS_CAL_CFG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // Control register bits
  localparam int unsigned CTRL_SRST = 0;
  localparam int unsigned CTRL_LINK_EN = 1;
  localparam int unsigned CTRL_CAL_EN = 2;
  localparam int unsigned CTRL_OVERRANGE_ENABLE = 3;
  localparam int unsigned CTRL_CAL_TRIG = 4;
  localparam int unsigned CTRL_SINGLE = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // Link configuration fields
  localparam int unsigned LCFG_MODE_LSB = 0;
  localparam int unsigned LCFG_KM1_LSB = 8;
  localparam int unsigned LCFG_SYNC_SEL = 16;
  localparam logic [4:0] LCFG_MODE_RST = 5'h00;
  localparam logic [4:0] LCFG_KM1_RST = 5'h1f;
  localparam logic LCFG_SYNC_RST = 1'b0;

  // Calibration configuration bits
  localparam int unsigned CCFG_BG = 0;
  localparam int unsigned CCFG_OFS = 1;
  localparam logic [1:0] CCFG_RST = 2'h0;

  // Status bits
  localparam int unsigned ST_SRST_BUSY = 0;
  localparam int unsigned ST_LINK_CGS = 1;
  localparam int unsigned ST_LINK_DATA = 2;
  localparam int unsigned ST_CAL_RUN = 3;
  localparam int unsigned ST_CAL_DONE = 4;
  localparam int unsigned ST_REJECT = 5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] link_mode_select;
    logic [4:0] multiframe_count_minus_one;
    logic sync_from_timestamp;
    logic overrange_enable;
    logic single_channel;
    logic dual_edge_sample;
    logic cal_background;
    logic cal_offset;
  } scs_cfg_t;

  typedef enum logic [2:0] {
    LK_HALT = 3'b001,
    LK_SYNC = 3'b010,
    LK_DATA = 3'b100
  } scs_link_st_t;

  typedef enum logic [2:0] {
    CL_HALT = 3'b001,
    CL_IDLE = 3'b010,
    CL_RUN = 3'b100
  } scs_cal_st_t;
endpackage
`default_nettype wire

// ==== logic/scs_sequencer.sv ====
// Function
// - Configuration follows one ordered sequence, and no write takes effect while a software reset settles.
// - Clearing link enable halts the link machine, and link settings only change while it is halted or on a software reset.
// - Clearing calibration enable halts the calibration machine, and its settings only change while halted or on a software reset.
// - The sync source bit picks the single-ended sync input or the timestamp pair as sync request.
// - Setting calibration enable restarts the calibration machine.
// - Setting link enable restarts the link machine and lets the link come up.
// - An enabled link sends sync code groups while the receiver requests sync and data otherwise.
// - A zero-to-one change of the calibration trigger bit starts a calibration when the calibration machine is idle.
// - Single-channel mode samples on both clock edges, so the clock rate never changes with the mode.
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer #(
  parameter int unsigned CAL_CYCLES = scs_pkg::CAL_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sync request pins, active low
  input wire logic sync_se_n,
  input wire logic sync_ts_n,
  // Converter side
  output scs_pkg::scs_cfg_t cfg,
  output logic link_send_cgs,
  output logic link_send_data,
  output logic cal_running,
  output logic cal_done
);
  // A run shorter than two cycles would break the start check below
  if (CAL_CYCLES < 2 || CAL_CYCLES > 65535) begin : g_cal_cycles_check
    $error("CAL_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [5:0] ctrl_q, ctrl_d;
  logic [4:0] mode_q, mode_d, km1_q, km1_d;
  logic sync_sel_q, sync_sel_d;
  logic [1:0] ccfg_q, ccfg_d;
  logic reject_q, reject_d;
  logic [7:0] srst_cnt_q, srst_cnt_d;
  logic done_q, done_d;
  logic acc, wr, hit, busy, srst_go, done_set;
  logic [31:0] wmask, w_ctrl, w_lcfg, w_ccfg;
  scs_pkg::scs_link_st_t lk_q, lk_d;
  scs_pkg::scs_cal_st_t cl_q, cl_d;
  logic [15:0] cal_cnt_q, cal_cnt_d;
  logic trig_prev_q, trig_rise;
  logic [1:0] sync_s1_q, sync_s2_q;
  logic sync_req;

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign busy = srst_cnt_q != 8'h00;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign w_ctrl = ({26'h0, ctrl_q} & ~wmask) | (pwdata & wmask);
  assign w_lcfg = ({15'h0, sync_sel_q, 3'h0, km1_q, 3'h0, mode_q} & ~wmask) | (pwdata & wmask);
  assign w_ccfg = ({30'h0, ccfg_q} & ~wmask) | (pwdata & wmask);
  // Writes during the settle window are dropped, not queued
  assign srst_go = wr & ~busy & (paddr == scs_pkg::OFS_CTRL) & w_ctrl[scs_pkg::CTRL_SRST];
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;

  always_comb begin
    ctrl_d = ctrl_q;
    mode_d = mode_q;
    km1_d = km1_q;
    sync_sel_d = sync_sel_q;
    ccfg_d = ccfg_q;
    reject_d = reject_q;
    srst_cnt_d = busy ? srst_cnt_q - 8'h01 : 8'h00;
    if (srst_go) begin
      ctrl_d = scs_pkg::CTRL_RST;
      mode_d = scs_pkg::LCFG_MODE_RST;
      km1_d = scs_pkg::LCFG_KM1_RST;
      sync_sel_d = scs_pkg::LCFG_SYNC_RST;
      ccfg_d = scs_pkg::CCFG_RST;
      reject_d = 1'b0;
      srst_cnt_d = 8'(scs_pkg::SRST_WAIT_CYC);
    end else if (wr && !busy) begin
      case (paddr)
        scs_pkg::OFS_CTRL: ctrl_d = {w_ctrl[5:1], 1'b0};
        scs_pkg::OFS_LINK_CFG: begin
          // Link settings frozen while the link machine runs
          if (!ctrl_q[scs_pkg::CTRL_LINK_EN]) begin
            mode_d = w_lcfg[scs_pkg::LCFG_MODE_LSB +: 5];
            km1_d = w_lcfg[scs_pkg::LCFG_KM1_LSB +: 5];
            sync_sel_d = w_lcfg[scs_pkg::LCFG_SYNC_SEL];
          end else begin
            reject_d = 1'b1;
          end
        end
        scs_pkg::OFS_CAL_CFG: begin
          if (!ctrl_q[scs_pkg::CTRL_CAL_EN]) begin
            ccfg_d = w_ccfg[1:0];
          end else begin
            reject_d = 1'b1;
          end
        end
        scs_pkg::OFS_STATUS: begin
          if (w_ccfg[scs_pkg::ST_REJECT] && pstrb[0]) begin
            reject_d = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= scs_pkg::CTRL_RST;
      mode_q <= scs_pkg::LCFG_MODE_RST;
      km1_q <= scs_pkg::LCFG_KM1_RST;
      sync_sel_q <= scs_pkg::LCFG_SYNC_RST;
      ccfg_q <= scs_pkg::CCFG_RST;
      reject_q <= 1'b0;
      srst_cnt_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      mode_q <= mode_d;
      km1_q <= km1_d;
      sync_sel_q <= sync_sel_d;
      ccfg_q <= ccfg_d;
      reject_q <= reject_d;
      srst_cnt_q <= srst_cnt_d;
    end
  end

  always_comb begin
    hit = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      scs_pkg::OFS_CTRL: prdata = {26'h0, ctrl_q};
      scs_pkg::OFS_LINK_CFG: prdata = {15'h0, sync_sel_q, 3'h0, km1_q, 3'h0, mode_q};
      scs_pkg::OFS_CAL_CFG: prdata = {30'h0, ccfg_q};
      scs_pkg::OFS_STATUS: prdata = {26'h0, reject_q, done_q, cal_running, link_send_data, link_send_cgs, busy};
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sync request input
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync_s1_q <= 2'h3;
      sync_s2_q <= 2'h3;
    end else begin
      sync_s1_q <= {sync_ts_n, sync_se_n};
      sync_s2_q <= sync_s1_q;
    end
  end
  assign sync_req = sync_sel_q ? ~sync_s2_q[1] : ~sync_s2_q[0];

  // ----------------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------------
  always_comb begin
    lk_d = lk_q;
    case (lk_q)
      scs_pkg::LK_HALT: if (ctrl_q[scs_pkg::CTRL_LINK_EN]) lk_d = scs_pkg::LK_SYNC;
      scs_pkg::LK_SYNC: if (!sync_req) lk_d = scs_pkg::LK_DATA;
      scs_pkg::LK_DATA: if (sync_req) lk_d = scs_pkg::LK_SYNC;
      default: lk_d = scs_pkg::LK_HALT;
    endcase
    if (!ctrl_q[scs_pkg::CTRL_LINK_EN]) lk_d = scs_pkg::LK_HALT;
  end

  // ----------------------------------------------------------------
  // Calibration state machine
  // ----------------------------------------------------------------
  assign trig_rise = ctrl_q[scs_pkg::CTRL_CAL_TRIG] & ~trig_prev_q;
  assign done_set = (cl_q == scs_pkg::CL_RUN) && (cal_cnt_q == 16'h0001);

  always_comb begin
    cl_d = cl_q;
    cal_cnt_d = cal_cnt_q;
    // Done clears on a new run; a finishing run wins
    done_d = done_set | (done_q & ~(cl_q == scs_pkg::CL_IDLE && trig_rise));
    case (cl_q)
      scs_pkg::CL_HALT: if (ctrl_q[scs_pkg::CTRL_CAL_EN]) cl_d = scs_pkg::CL_IDLE;
      scs_pkg::CL_IDLE: begin
        if (trig_rise) begin
          cl_d = scs_pkg::CL_RUN;
          cal_cnt_d = 16'(CAL_CYCLES);
        end
      end
      scs_pkg::CL_RUN: begin
        cal_cnt_d = cal_cnt_q - 16'h0001;
        if (cal_cnt_q == 16'h0001) cl_d = scs_pkg::CL_IDLE;
      end
      default: cl_d = scs_pkg::CL_HALT;
    endcase
    // Halting aborts a run in progress
    if (!ctrl_q[scs_pkg::CTRL_CAL_EN]) begin
      cl_d = scs_pkg::CL_HALT;
      cal_cnt_d = 16'h0000;
    end
    if (srst_go) done_d = 1'b0;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lk_q <= scs_pkg::LK_HALT;
      cl_q <= scs_pkg::CL_HALT;
      cal_cnt_q <= 16'h0000;
      trig_prev_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      lk_q <= lk_d;
      cl_q <= cl_d;
      cal_cnt_q <= cal_cnt_d;
      trig_prev_q <= ctrl_q[scs_pkg::CTRL_CAL_TRIG];
      done_q <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link_send_cgs = lk_q == scs_pkg::LK_SYNC;
  assign link_send_data = lk_q == scs_pkg::LK_DATA;
  assign cal_running = cl_q == scs_pkg::CL_RUN;
  assign cal_done = done_q;
  // One driver for the whole struct; both edges in single-channel mode keep the clock rate fixed
  assign cfg = '{
    link_mode_select: mode_q,
    multiframe_count_minus_one: km1_q,
    sync_from_timestamp: sync_sel_q,
    overrange_enable: ctrl_q[scs_pkg::CTRL_OVERRANGE_ENABLE],
    single_channel: ctrl_q[scs_pkg::CTRL_SINGLE],
    dual_edge_sample: ctrl_q[scs_pkg::CTRL_SINGLE],
    cal_background: ccfg_q[scs_pkg::CCFG_BG],
    cal_offset: ccfg_q[scs_pkg::CCFG_OFS]
  };

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_srst_settle: assert property (srst_go |=> busy && !ctrl_q[scs_pkg::CTRL_LINK_EN]
    && srst_cnt_q == 8'(scs_pkg::SRST_WAIT_CYC)) else $error("soft reset settle not loaded");
  chk_busy_ignores: assert property ((wr && busy) |=> $stable(ctrl_q) && $stable(mode_q)
    && $stable(ccfg_q)) else $error("write taken during settle");
  chk_link_lock: assert property ((ctrl_q[scs_pkg::CTRL_LINK_EN] && !srst_go) |=> $stable(mode_q)
    && $stable(km1_q) && $stable(sync_sel_q)) else $error("link settings changed while running");
  chk_cal_lock: assert property ((ctrl_q[scs_pkg::CTRL_CAL_EN] && !srst_go) |=> $stable(ccfg_q))
    else $error("cal settings changed while running");
  chk_cal_halt: assert property (!ctrl_q[scs_pkg::CTRL_CAL_EN] |=> cl_q == scs_pkg::CL_HALT)
    else $error("cal machine not halted");
  chk_link_start: assert property ((lk_q == scs_pkg::LK_HALT && ctrl_q[scs_pkg::CTRL_LINK_EN])
    |=> lk_q == scs_pkg::LK_SYNC) else $error("link did not restart");
  chk_link_sync: assert property ((lk_q == scs_pkg::LK_SYNC && ctrl_q[scs_pkg::CTRL_LINK_EN] && !sync_req)
    |=> link_send_data) else $error("link ignored released sync");
  chk_sync_source: assert property ($rose(sync_s2_q[1]) && sync_sel_q && $stable(sync_s2_q[0])
    |-> !sync_req) else $error("sync source mismatch");
  chk_trig_start: assert property ((cl_q == scs_pkg::CL_IDLE && trig_rise && ctrl_q[scs_pkg::CTRL_CAL_EN])
    |=> cal_running ##1 cal_running) else $error("trigger did not start calibration");
  chk_dual_edge: assert property ($changed(cfg.single_channel) |-> $changed(cfg.dual_edge_sample))
    else $error("sampling edge mode not following channel mode");
endmodule
`default_nettype wire

// ==== bench/scs_sync_rx.sv ====
`timescale 1ns/1ps
`default_nettype none
module scs_sync_rx #(
  parameter int unsigned HOLD = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Link state of the device
  input wire logic link_send_cgs,
  input wire logic link_send_data,
  input wire logic sel_ts,
  // Sync request pins, active low
  output logic sync_se_n,
  output logic sync_ts_n
);
  logic [7:0] cnt_q;
  logic req_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 8'h00;
      req_q <= 1'b1;
    end else if (!link_send_cgs && !link_send_data) begin
      // Halted link: ask for sync again when it restarts
      cnt_q <= 8'h00;
      req_q <= 1'b1;
    end else if (link_send_cgs && cnt_q < 8'(HOLD)) begin
      cnt_q <= cnt_q + 8'h01;
    end else if (link_send_cgs) begin
      req_q <= 1'b0;
    end
  end

  // Only the selected pin carries the request; the other stays released
  assign sync_se_n = sel_ts ? 1'b1 : !req_q;
  assign sync_ts_n = sel_ts ? !req_q : 1'b1;
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Long enough that an abort lands mid-run
  localparam int unsigned CAL_N = 16;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sync_se_n;
  logic sync_ts_n;
  logic sel_ts = 1'b0;
  scs_pkg::scs_cfg_t cfg;
  logic link_send_cgs;
  logic link_send_data;
  logic cal_running;
  logic cal_done;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int checked = 0;
  int n;

  always #5 clk_sys = ~clk_sys;

  scs_sequencer #(.CAL_CYCLES(CAL_N)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sync_se_n(sync_se_n), .sync_ts_n(sync_ts_n), .cfg(cfg), .link_send_cgs(link_send_cgs),
    .link_send_data(link_send_data), .cal_running(cal_running), .cal_done(cal_done));

  scs_sync_rx u_rx (.clk_sys(clk_sys), .sys_rst(sys_rst), .link_send_cgs(link_send_cgs),
    .link_send_data(link_send_data), .sel_ts(sel_ts), .sync_se_n(sync_se_n), .sync_ts_n(sync_ts_n));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(nm, exp, rd);
  endtask

  task automatic settle();
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Startup sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rchk("ctrl_rst", scs_pkg::OFS_CTRL, 32'h0);
    rchk("link_cfg_rst", scs_pkg::OFS_LINK_CFG, 32'h00001f00);
    rchk("cal_cfg_rst", scs_pkg::OFS_CAL_CFG, 32'h0);
    apb(scs_pkg::OFS_CTRL, 1'b1, 32'h1);
    apb(scs_pkg::OFS_LINK_CFG, 1'b1, 32'h00000305);
    rchk("busy", scs_pkg::OFS_STATUS, 32'h1);
    repeat (scs_pkg::SRST_WAIT_CYC) @(posedge clk_sys);
    rchk("busy_end", scs_pkg::OFS_STATUS, 32'h0);
    rchk("dropped", scs_pkg::OFS_LINK_CFG, 32'h00001f00);
    apb(8'h10, 1'b0, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, rd);
    // Both sync sources, each with a held request
    for (int s = 0; s < 2; s++) begin
      apb(scs_pkg::OFS_CTRL, 1'b1, 32'h0);
      settle();
      chk("halted", 32'h0, {30'h0, link_send_cgs, link_send_data});
      apb(scs_pkg::OFS_LINK_CFG, 1'b1, {15'h0, 1'(s), 3'h0, 5'h0f, 3'h0, 5'h0a});
      sel_ts <= 1'(s);
      settle();
      chk("mode", 32'h0a, 32'(cfg.link_mode_select));
      chk("km1", 32'h0f, 32'(cfg.multiframe_count_minus_one));
      chk("sync_sel", 32'(s), 32'(cfg.sync_from_timestamp));
      apb(scs_pkg::OFS_CTRL, 1'b1, 32'h6);
      settle();
      chk("cgs", 32'h1, 32'(link_send_cgs));
      repeat (8) @(negedge clk_sys);
      chk("cgs_held", 32'h1, 32'(link_send_cgs));
      n = 0;
      while (link_send_data !== 1'b1 && n < 40) begin
        @(negedge clk_sys);
        n++;
      end
      chk("data", 32'h1, 32'(link_send_data));
    end
    // Settings locked while machines run
    apb(scs_pkg::OFS_LINK_CFG, 1'b1, 32'h0);
    rchk("locked", scs_pkg::OFS_LINK_CFG, 32'h00010f0a);
    apb(scs_pkg::OFS_CAL_CFG, 1'b1, 32'h3);
    rchk("cal_locked", scs_pkg::OFS_CAL_CFG, 32'h0);
    rchk("reject", scs_pkg::OFS_STATUS, 32'h24);
    apb(scs_pkg::OFS_STATUS, 1'b1, 32'h20);
    rchk("reject_clr", scs_pkg::OFS_STATUS, 32'h04);
    apb(scs_pkg::OFS_CTRL, 1'b1, 32'h2);
    apb(scs_pkg::OFS_CAL_CFG, 1'b1, 32'h3);
    settle();
    chk("cal_cfg", 32'h3, {30'h0, cfg.cal_background, cfg.cal_offset});
    apb(scs_pkg::OFS_CTRL, 1'b1, 32'h6);
    apb(scs_pkg::OFS_CTRL, 1'b1, 32'he);
    settle();
    chk("ovr", 32'h1, 32'(cfg.overrange_enable));
    // Trigger, retrigger without a zero, then abort
    for (int t = 0; t < 2; t++) begin
      apb(scs_pkg::OFS_CTRL, 1'b1, 32'h1e);
      repeat (4) @(negedge clk_sys);
      chk("cal_start", 32'(t == 0), 32'(cal_running));
      n = 0;
      while (cal_done !== 1'b1 && n < CAL_N + 20) begin
        @(negedge clk_sys);
        n++;
      end
      chk("cal_done", 32'h2, {30'h0, cal_done, cal_running});
    end
    apb(scs_pkg::OFS_CTRL, 1'b1, 32'h0e);
    apb(scs_pkg::OFS_CTRL, 1'b1, 32'h1e);
    apb(scs_pkg::OFS_CTRL, 1'b1, 32'h1a);
    settle();
    chk("cal_abort", 32'h0, {30'h0, cal_done, cal_running});
    apb(scs_pkg::OFS_CTRL, 1'b1, 32'h2e);
    settle();
    chk("single", 32'h3, {30'h0, cfg.single_channel, cfg.dual_edge_sample});
    apb(scs_pkg::OFS_CTRL, 1'b1, 32'h0e);
    settle();
    chk("dual", 32'h0, {30'h0, cfg.single_channel, cfg.dual_edge_sample});
    stop_test();
  end
endmodule
`default_nettype wire
